// ==== logic/cpu_flow_control.sv ====
// Behaviour
// - One flat 64 KB space, 16-bit addresses for code, data and registers.
// - Addresses 0000H to 0013H hold reset and interrupt start addresses.
// - Vector low byte at even address, high byte at next odd address.
// - Fixed vector slot per source; converter slot only on converter variants.
// - One-byte table call reads its entry from 0040H to 007FH.
// - Option byte sits at program address 0080H.
// - Protect byte sits at program address 0081H.
// - Program flash is 1, 2 or 4 KB from address zero.
// - 128 bytes of fast RAM, usable as stack.
// - Fast RAM occupies FE80H to FEFFH.
// - Special registers occupy FF00H to FFFFH.
// - Fetch pointer is 16 bits, addressing the next instruction.
// - Sequential execution advances the pointer by instruction length.
// - Branch loads the pointer with the given target.
// - Reset loads the pointer from bytes at 0000H and 0001H.
// - Flag word: enable, zero, half carry, carry; bit 1 one, others zero.
// - Flag word pushed on acknowledge or push, restored on return or pop.
// - Reset sets the flag word to 02H.
// - Interrupt enable clear blocks every maskable request.
// - With enable set, each source is also gated by its mask.
// - Enable clears on mask-all or acknowledge, sets on unmask-all.
// - Zero flag set for a zero result, else cleared.
// - Half carry flag tracks carry or borrow at bit 3.
// - Carry flag takes overflow, shifted-out bit or bit accumulator value.
// - Stack pointer decrements before a write, increments after a read.
// - Only the low 10 stack pointer bits are settable.
`default_nettype none
module cpu_flow_control #(
   parameter logic [16:0] ROM_BYTES = cpu_flow_pkg::ROM_LARGE,
   parameter logic HAS_CONVERTER = 1'b1
) (
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [2:0] regAddr,
   input wire logic [15:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regReadData,
   // Command port from the decoder
   input wire logic cmdStrobe,
   input wire cpu_flow_pkg::cmd_type cmdKind,
   input wire logic [2:0] cmdLength,
   input wire logic [15:0] cmdTarget,
   input wire logic [4:0] cmdTableIndex,
   input wire logic zeroResult,
   input wire logic halfCarry,
   input wire logic carryOut,
   input wire logic updateZero,
   input wire logic updateHalf,
   input wire logic updateCarry,
   output logic busy,
   // Interrupt sources
   input wire logic [6:0] irqRequest,
   output logic irqAck,
   output logic [2:0] irqAckSource,
   // Memory port
   output logic [15:0] memAddr,
   output logic [7:0] memWriteData,
   output logic memWrite,
   output logic memRead,
   output cpu_flow_pkg::region_type memRegion,
   input wire logic [7:0] memReadData,
   // Processor state
   output logic [15:0] fetchPointer,
   output logic [7:0] flagWord,
   output logic [15:0] stackPointer,
   output logic [7:0] optionByte,
   output logic [7:0] protectByte
);
   import cpu_flow_pkg::*;

   typedef enum logic [3:0] {
      ST_OPTION, ST_PROTECT, ST_VEC_LO, ST_VEC_HI, ST_IDLE,
      ST_PUSH_FLAGS, ST_PUSH_HI, ST_PUSH_LO,
      ST_POP_LO, ST_POP_HI, ST_POP_FLAGS
   } state_type;

   state_type state;
   state_type next_state;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [9:0] stackLow;
   logic [6:0] irqMask;
   logic [15:0] vecAddr;
   logic [7:0] lowByte;
   logic [7:0] savedFlags;
   logic serviceIrq;
   logic isRead;
   logic isWrite;
   logic accessDone;
   logic [15:0] accessAddr;
   logic [7:0] writeByte;
   logic [6:0] irqPresent;
   logic [6:0] irqLive;
   logic irqTake;
   logic [2:0] irqPick;
   logic cmdTake;

   function automatic logic [15:0] vectorOf(input logic [2:0] src);
      case (src)
         3'h0: vectorOf = VEC_LOW_VOLT;
         3'h1: vectorOf = VEC_EXT0;
         3'h2: vectorOf = VEC_EXT1;
         3'h3: vectorOf = VEC_TIMER_H1;
         3'h4: vectorOf = VEC_TIMER00_0;
         3'h5: vectorOf = VEC_TIMER00_1;
         default: vectorOf = VEC_ADC_DONE;
      endcase
   endfunction : vectorOf

   function automatic region_type regionOf(input logic [15:0] a);
      if ({1'b0, a} < ROM_BYTES) begin
         regionOf = REGION_ROM;
      end else if (a >= RAM_BASE && a <= RAM_END) begin
         regionOf = REGION_RAM;
      end else if (a >= SFR_BASE) begin
         regionOf = REGION_SFR;
      end else begin
         regionOf = REGION_NONE;
      end
   endfunction : regionOf

   function automatic logic [7:0] fixFlags(input logic [7:0] d);
      fixFlags = (d & FLAG_KEEP) | FLAG_ONES;
   endfunction : fixFlags

   // Interrupt gating
   generate
      for (genvar i = 0; i < IRQ_COUNT; i++) begin : gIrq
         if (i == IRQ_ADC) begin : gAdc
            assign irqPresent[i] = HAS_CONVERTER;
         end else begin : gPlain
            assign irqPresent[i] = 1'b1;
         end
         assign irqLive[i] = irqRequest[i] & ~irqMask[i] & irqPresent[i];
      end
   endgenerate

   always_comb begin
      irqPick = 3'h0;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (irqLive[i]) begin
            irqPick = 3'(i);
         end
      end
   end

   assign cmdTake = (state == ST_IDLE) && cmdStrobe;
   assign irqTake = (state == ST_IDLE) && !cmdStrobe && flagWord[FLAG_IE]
      && (|irqLive);

   // Access classification and addressing
   always_comb begin
      isRead = 1'b0;
      isWrite = 1'b0;
      accessAddr = {STACK_UPPER, stackLow};
      writeByte = 8'h00;
      case (state)
         ST_OPTION: begin
            isRead = 1'b1;
            accessAddr = OPTION_ADDR;
         end
         ST_PROTECT: begin
            isRead = 1'b1;
            accessAddr = PROTECT_ADDR;
         end
         ST_VEC_LO: begin
            isRead = 1'b1;
            accessAddr = vecAddr;
         end
         ST_VEC_HI: begin
            isRead = 1'b1;
            accessAddr = vecAddr + 16'h0001;
         end
         ST_PUSH_FLAGS: begin
            isWrite = 1'b1;
            accessAddr = {STACK_UPPER, stackLow - 10'h001};
            writeByte = savedFlags;
         end
         ST_PUSH_HI: begin
            isWrite = 1'b1;
            accessAddr = {STACK_UPPER, stackLow - 10'h001};
            writeByte = fetchPointer[15:8];
         end
         ST_PUSH_LO: begin
            isWrite = 1'b1;
            accessAddr = {STACK_UPPER, stackLow - 10'h001};
            writeByte = fetchPointer[7:0];
         end
         ST_POP_LO, ST_POP_HI, ST_POP_FLAGS: begin
            isRead = 1'b1;
         end
         default: begin
            isRead = 1'b0;
         end
      endcase
   end

   assign accessDone = (isWrite && phase == 2'h1) || (isRead && phase == 2'h2);

   // Sequencer
   always_comb begin
      next_state = state;
      next_phase = phase;
      if (state == ST_IDLE) begin
         next_phase = 2'h0;
         if (cmdTake) begin
            case (cmdKind)
               CMD_TABLE_CALL: next_state = ST_PUSH_HI;
               CMD_PUSH_FLAGS: next_state = ST_PUSH_FLAGS;
               CMD_POP_FLAGS: next_state = ST_POP_FLAGS;
               CMD_INT_RETURN: next_state = ST_POP_LO;
               default: next_state = ST_IDLE;
            endcase
         end else if (irqTake) begin
            next_state = ST_PUSH_FLAGS;
         end
      end else if (accessDone) begin
         next_phase = 2'h0;
         case (state)
            ST_OPTION: next_state = ST_PROTECT;
            ST_PROTECT: next_state = ST_VEC_LO;
            ST_VEC_LO: next_state = ST_VEC_HI;
            ST_PUSH_FLAGS: next_state = serviceIrq ? ST_PUSH_HI : ST_IDLE;
            ST_PUSH_HI: next_state = ST_PUSH_LO;
            ST_PUSH_LO: next_state = ST_VEC_LO;
            ST_POP_LO: next_state = ST_POP_HI;
            ST_POP_HI: next_state = ST_POP_FLAGS;
            default: next_state = ST_IDLE;
         endcase
      end else begin
         next_phase = phase + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_OPTION;
         phase <= 2'h0;
         busy <= 1'b1;
      end else begin
         state <= next_state;
         phase <= next_phase;
         busy <= (next_state != ST_IDLE);
      end
   end

   // Vector and service context
   always_ff @(posedge clock) begin
      if (rst) begin
         vecAddr <= VEC_RESET;
         serviceIrq <= 1'b0;
         savedFlags <= FLAG_RESET;
      end else if (irqTake) begin
         vecAddr <= vectorOf(irqPick);
         serviceIrq <= 1'b1;
         savedFlags <= flagWord;
      end else if (cmdTake && cmdKind == CMD_TABLE_CALL) begin
         vecAddr <= TABLE_BASE + {10'h000, cmdTableIndex, 1'b0};
         serviceIrq <= 1'b0;
      end else if (cmdTake && cmdKind == CMD_PUSH_FLAGS) begin
         serviceIrq <= 1'b0;
         savedFlags <= flagWord;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irqAck <= 1'b0;
         irqAckSource <= 3'h0;
      end else begin
         irqAck <= irqTake;
         if (irqTake) begin
            irqAckSource <= irqPick;
         end
      end
   end

   // Memory port
   always_ff @(posedge clock) begin
      if (rst) begin
         memRead <= 1'b0;
         memWrite <= 1'b0;
         memAddr <= 16'h0000;
         memWriteData <= 8'h00;
         memRegion <= REGION_ROM;
      end else begin
         memRead <= isRead && phase == 2'h0;
         memWrite <= isWrite && phase == 2'h0;
         if (phase == 2'h0 && (isRead || isWrite)) begin
            memAddr <= accessAddr;
            memWriteData <= writeByte;
            memRegion <= regionOf(accessAddr);
         end
      end
   end

   // Configuration bytes fetched after reset, and the low byte of each vector read
   always_ff @(posedge clock) begin
      if (rst) begin
         optionByte <= 8'h00;
         protectByte <= 8'h00;
         lowByte <= 8'h00;
      end else if (accessDone) begin
         if (state == ST_OPTION) begin
            optionByte <= memReadData;
         end
         if (state == ST_PROTECT) begin
            protectByte <= memReadData;
         end
         if (state == ST_VEC_LO) begin
            lowByte <= memReadData;
         end
      end
   end

   // Fetch pointer
   always_ff @(posedge clock) begin
      if (rst) begin
         fetchPointer <= 16'h0000;
      end else if (accessDone && state == ST_VEC_HI) begin
         fetchPointer <= {memReadData, lowByte};
      end else if (accessDone && state == ST_POP_LO) begin
         fetchPointer[7:0] <= memReadData;
      end else if (accessDone && state == ST_POP_HI) begin
         fetchPointer[15:8] <= memReadData;
      end else if (cmdTake && cmdKind == CMD_BRANCH) begin
         fetchPointer <= cmdTarget;
      end else if (cmdTake && (cmdKind == CMD_SEQUENCE || cmdKind == CMD_TABLE_CALL)) begin
         fetchPointer <= fetchPointer + {13'h0000, cmdLength};
      end else if (state == ST_IDLE && regWrite && regAddr == REG_FETCH) begin
         fetchPointer <= regWriteData;
      end
   end

   // Flag word
   always_ff @(posedge clock) begin
      if (rst) begin
         flagWord <= FLAG_RESET;
      end else if (accessDone && state == ST_POP_FLAGS) begin
         flagWord <= fixFlags(memReadData);
      end else if (cmdTake && cmdKind == CMD_MASK_ALL) begin
         flagWord[FLAG_IE] <= 1'b0;
      end else if (cmdTake && cmdKind == CMD_UNMASK_ALL) begin
         flagWord[FLAG_IE] <= 1'b1;
      end else if (cmdTake && cmdKind == CMD_FLAG_UPDATE) begin
         if (updateZero) begin
            flagWord[FLAG_ZERO] <= zeroResult;
         end
         if (updateHalf) begin
            flagWord[FLAG_HALF] <= halfCarry;
         end
         if (updateCarry) begin
            flagWord[FLAG_CARRY] <= carryOut;
         end
      end else if (irqTake) begin
         flagWord[FLAG_IE] <= 1'b0;
      end else if (state == ST_IDLE && regWrite && regAddr == REG_FLAGS) begin
         flagWord <= fixFlags(regWriteData[7:0]);
      end
   end

   // Stack pointer
   always_ff @(posedge clock) begin
      if (rst) begin
         stackLow <= 10'h000;
      end else if (isWrite && phase == 2'h0) begin
         stackLow <= stackLow - 10'h001;
      end else if (isRead && accessDone && state >= ST_POP_LO) begin
         stackLow <= stackLow + 10'h001;
      end else if (state == ST_IDLE && regWrite && regAddr == REG_STACK) begin
         stackLow <= regWriteData[9:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         stackPointer <= {STACK_UPPER, 10'h000};
      end else begin
         stackPointer <= {STACK_UPPER, stackLow};
      end
   end

   // Interrupt masks
   always_ff @(posedge clock) begin
      if (rst) begin
         irqMask <= IRQ_MASK_RESET;
      end else if (regWrite && regAddr == REG_IRQ_MASK) begin
         irqMask <= regWriteData[6:0];
      end
   end

   // Register read
   always_ff @(posedge clock) begin
      if (rst) begin
         regReadData <= 16'h0000;
      end else if (regRead) begin
         if (regAddr == REG_FETCH) begin
            regReadData <= fetchPointer;
         end else if (regAddr == REG_FLAGS) begin
            regReadData <= {8'h00, flagWord};
         end else if (regAddr == REG_STACK) begin
            regReadData <= {STACK_UPPER, stackLow};
         end else if (regAddr == REG_IRQ_MASK) begin
            regReadData <= {9'h000, irqMask};
         end else if (regAddr == REG_STATUS) begin
            regReadData <= {7'h00, busy, 1'b0, irqLive};
         end else begin
            regReadData <= 16'h0000;
         end
      end else begin
         regReadData <= 16'h0000;
      end
   end
endmodule : cpu_flow_control
`default_nettype wire

// ==== logic/cpu_flow_pkg.sv ====
`default_nettype none
package cpu_flow_pkg;
   // Address map
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_AREA_END = 16'h0013;
   localparam logic [15:0] VEC_LOW_VOLT = 16'h0006;
   localparam logic [15:0] VEC_EXT0 = 16'h0008;
   localparam logic [15:0] VEC_EXT1 = 16'h000A;
   localparam logic [15:0] VEC_TIMER_H1 = 16'h000C;
   localparam logic [15:0] VEC_TIMER00_0 = 16'h000E;
   localparam logic [15:0] VEC_TIMER00_1 = 16'h0010;
   localparam logic [15:0] VEC_ADC_DONE = 16'h0012;
   localparam logic [15:0] TABLE_BASE = 16'h0040;
   localparam logic [15:0] TABLE_END = 16'h007F;
   localparam logic [15:0] OPTION_ADDR = 16'h0080;
   localparam logic [15:0] PROTECT_ADDR = 16'h0081;
   localparam logic [15:0] RAM_BASE = 16'hFE80;
   localparam logic [15:0] RAM_END = 16'hFEFF;
   localparam logic [15:0] SFR_BASE = 16'hFF00;
   localparam logic [16:0] ROM_SMALL = 17'h00400;
   localparam logic [16:0] ROM_MEDIUM = 17'h00800;
   localparam logic [16:0] ROM_LARGE = 17'h01000;
   localparam logic [5:0] STACK_UPPER = 6'h3F;
   // Flag word layout
   localparam int FLAG_IE = 7;
   localparam int FLAG_ZERO = 6;
   localparam int FLAG_HALF = 4;
   localparam int FLAG_CARRY = 0;
   localparam logic [7:0] FLAG_RESET = 8'h02;
   localparam logic [7:0] FLAG_KEEP = 8'hD1;
   localparam logic [7:0] FLAG_ONES = 8'h02;
   localparam int IRQ_COUNT = 7;
   localparam int IRQ_ADC = 6;
   // Register port offsets
   localparam logic [2:0] REG_FETCH = 3'h0;
   localparam logic [2:0] REG_FLAGS = 3'h1;
   localparam logic [2:0] REG_STACK = 3'h2;
   localparam logic [2:0] REG_IRQ_MASK = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [6:0] IRQ_MASK_RESET = 7'h7F;

   typedef enum logic [3:0] {
      CMD_SEQUENCE, CMD_BRANCH, CMD_TABLE_CALL, CMD_MASK_ALL, CMD_UNMASK_ALL,
      CMD_PUSH_FLAGS, CMD_POP_FLAGS, CMD_INT_RETURN, CMD_FLAG_UPDATE
   } cmd_type;

   typedef enum logic [1:0] {
      REGION_ROM, REGION_RAM, REGION_SFR, REGION_NONE
   } region_type;
endpackage : cpu_flow_pkg
`default_nettype wire

// ==== sim/cpu_flow_control_chk.sv ====
`default_nettype none
module cpu_flow_control_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Command port
   input wire logic cmdStrobe,
   input wire cpu_flow_pkg::cmd_type cmdKind,
   input wire logic [15:0] cmdTarget,
   input wire logic zeroResult,
   input wire logic updateZero,
   input wire logic busy,
   // Interrupts
   input wire logic [6:0] irqRequest,
   input wire logic irqAck,
   input wire logic [2:0] irqAckSource,
   // Memory port
   input wire logic [15:0] memAddr,
   input wire logic [7:0] memWriteData,
   input wire logic memWrite,
   input wire logic memRead,
   input wire logic [7:0] memReadData,
   // Processor state
   input wire logic [15:0] fetchPointer,
   input wire logic [7:0] flagWord,
   input wire logic [15:0] stackPointer
);
   timeunit 1ns;
   timeprecision 100ps;
   import cpu_flow_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   logic take;
   logic [6:0] lastReq;
   logic [15:0] vecAddr;
   assign take = cmdStrobe && !busy;
   assign vecAddr = 16'h0006 + {12'h000, irqAckSource, 1'b0};
   always_ff @(posedge clock) begin
      lastReq <= irqRequest;
   end
   AST_FIXED_BITS: assert property ((flagWord & 8'h2E) == 8'h02)
      else $error("flag word fixed bits wrong");
   AST_ACK_NEEDS_IE: assert property (irqAck |-> $past(flagWord[7]))
      else $error("acknowledge with enable clear");
   AST_ACK_SOURCE: assert property (irqAck |-> lastReq[irqAckSource] &&
      (lastReq & ((7'h01 << irqAckSource) - 7'h01)) == 7'h00)
      else $error("acknowledged source not lowest request");
   AST_ACK_CLEARS_IE: assert property (irqAck |-> !flagWord[7])
      else $error("enable not cleared by acknowledge");
   AST_MASK_CMD: assert property (take &&
      (cmdKind == CMD_MASK_ALL || cmdKind == CMD_UNMASK_ALL)
      |=> flagWord[7] == ($past(cmdKind) == CMD_UNMASK_ALL))
      else $error("enable wrong after mask command");
   AST_ACK_PUSH: assert property (irqAck |=> memWrite &&
      memWriteData == $past(flagWord, 2) && memAddr == {6'h3F, stackPointer[9:0] - 10'h001})
      else $error("flag word not pushed first");
   AST_SP_DEC: assert property (memWrite |=> stackPointer == $past(memAddr))
      else $error("stack pointer not at written slot");
   AST_SP_UPPER: assert property (stackPointer[15:10] == 6'h3F)
      else $error("stack pointer upper bits wrong");
   AST_VECTOR_READ: assert property (irqAck |-> ##7 (memRead && memAddr == vecAddr)
      ##3 (memRead && memAddr == vecAddr + 16'h0001))
      else $error("vector bytes not read");
   AST_VECTOR_LOAD: assert property (irqAck |->
      ##12 fetchPointer == {$past(memReadData, 1), $past(memReadData, 4)})
      else $error("fetch pointer not loaded from vector");
   AST_BRANCH: assert property (take && cmdKind == CMD_BRANCH
      |=> fetchPointer == $past(cmdTarget))
      else $error("branch target not loaded");
   AST_ZERO: assert property (take && cmdKind == CMD_FLAG_UPDATE && updateZero
      |=> flagWord[6] == $past(zeroResult))
      else $error("zero flag not updated");
endmodule : cpu_flow_control_chk
bind cpu_flow_control cpu_flow_control_chk chk (
   .clock, .rst, .cmdStrobe, .cmdKind, .cmdTarget, .zeroResult, .updateZero, .busy,
   .irqRequest, .irqAck, .irqAckSource, .memAddr, .memWriteData, .memWrite, .memRead,
   .memReadData, .fetchPointer, .flagWord, .stackPointer
);
`default_nettype wire

// ==== sim/cpu_flow_mem_model.sv ====
`default_nettype none
module cpu_flow_mem_model (
   // Clock
   input wire logic clock,
   // Memory port
   input wire logic [15:0] memAddr,
   input wire logic [7:0] memWriteData,
   input wire logic memWrite,
   input wire logic memRead,
   output logic [7:0] memReadData
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] store [0:65535];
   // Fixed pattern makes vectors, table entries and option bytes predictable
   initial begin
      for (int i = 0; i < 65536; i++) begin
         store[i] = 8'(i) ^ 8'hA5;
      end
      memReadData = 8'h00;
   end
   always @(posedge clock) begin
      if (memWrite) begin
         store[memAddr] <= memWriteData;
      end
   end
   // Data stand one cycle after a read only; otherwise they toggle
   always @(posedge clock) begin
      if (memRead) begin
         memReadData <= store[memAddr];
      end else begin
         memReadData <= ~memReadData;
      end
   end
endmodule : cpu_flow_mem_model
`default_nettype wire

// ==== sim/tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import cpu_flow_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [15:0] regWriteData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic cmdStrobe = 1'b0;
   cmd_type cmdKind = CMD_SEQUENCE;
   logic [2:0] cmdLength = 3'h0;
   logic [15:0] cmdTarget = 16'h0000;
   logic [4:0] cmdTableIndex = 5'h00;
   logic [5:0] alu = 6'h00;
   logic [6:0] irqRequest = 7'h00;
   logic busy, irqAck, memWrite, memRead;
   logic [2:0] irqAckSource;
   logic [15:0] regReadData, memAddr, fetchPointer, stackPointer, fe;
   logic [7:0] memWriteData, memReadData, flagWord, optionByte, protectByte;
   region_type memRegion;
   int bad_count = 0;
   int cmp_count = 0;
   always #2 clock = ~clock;
   cpu_flow_control uut (
      .clock, .rst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
      .cmdStrobe, .cmdKind, .cmdLength, .cmdTarget, .cmdTableIndex,
      .zeroResult(alu[5]), .halfCarry(alu[4]), .carryOut(alu[3]),
      .updateZero(alu[2]), .updateHalf(alu[1]), .updateCarry(alu[0]),
      .busy, .irqRequest, .irqAck, .irqAckSource, .memAddr, .memWriteData,
      .memWrite, .memRead, .memRegion, .memReadData, .fetchPointer, .flagWord,
      .stackPointer, .optionByte, .protectByte
   );
   cpu_flow_mem_model mdl (
      .clock, .memAddr, .memWriteData, .memWrite, .memRead, .memReadData
   );
   // Same fill pattern as the memory model
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction : pat
   function automatic logic [15:0] vec(input logic [15:0] a);
      return {pat(a + 16'h0001), pat(a)};
   endfunction : vec
   task automatic summarize;
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      chk(regReadData, e);
   endtask : rd
   task automatic idle;
      for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
         @(posedge clock);
         #1;
      end
      chk({15'h0000, busy}, 16'h0000);
   endtask : idle
   task automatic cmd(input cmd_type k, input logic [2:0] n, input logic [15:0] t,
         input logic [4:0] x, input logic [5:0] f);
      @(posedge clock);
      cmdKind <= k;
      cmdLength <= n;
      cmdTarget <= t;
      cmdTableIndex <= x;
      alu <= f;
      cmdStrobe <= 1'b1;
      @(posedge clock);
      cmdStrobe <= 1'b0;
      #1;
      idle();
   endtask : cmd
   task automatic quiet;
      repeat (8) begin
         @(posedge clock);
         #1;
         chk({15'h0000, irqAck}, 16'h0000);
      end
   endtask : quiet
   initial begin
      repeat (5000) @(posedge clock);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      idle();
      chk(fetchPointer, vec(16'h0000));
      chk({optionByte, protectByte}, {pat(16'h0080), pat(16'h0081)});
      chk({8'h00, flagWord}, 16'h0002);
      rd(3'h1, 16'h0002);
      rd(3'h2, 16'hFC00);
      rd(3'h5, 16'h0000);
      wr(3'h2, 16'h0300);
      rd(3'h2, 16'hFF00);
      wr(3'h1, 16'h00FF);
      rd(3'h1, 16'h00D3);
      cmd(CMD_SEQUENCE, 3'h3, 16'h0000, 5'h00, 6'h00);
      chk(fetchPointer, vec(16'h0000) + 16'h0003);
      cmd(CMD_BRANCH, 3'h0, 16'hABCD, 5'h00, 6'h00);
      chk(fetchPointer, 16'hABCD);
      cmd(CMD_TABLE_CALL, 3'h1, 16'h0000, 5'h1F, 6'h00);
      fe = vec(16'h007E);
      chk(fetchPointer, fe);
      chk({14'h0000, memRegion}, {14'h0000, REGION_ROM});
      chk(stackPointer, 16'hFEFE);
      chk({mdl.store[16'hFEFF], mdl.store[16'hFEFE]}, 16'hABCE);
      cmd(CMD_PUSH_FLAGS, 3'h0, 16'h0000, 5'h00, 6'h00);
      chk(stackPointer, 16'hFEFD);
      chk({14'h0000, memRegion}, {14'h0000, REGION_RAM});
      wr(3'h1, 16'h0000);
      cmd(CMD_POP_FLAGS, 3'h0, 16'h0000, 5'h00, 6'h00);
      // Stack pointer output trails the increment by one cycle
      @(posedge clock);
      #1;
      chk({flagWord, stackPointer[7:0]}, 16'hD3FE);
      cmd(CMD_FLAG_UPDATE, 3'h0, 16'h0000, 5'h00, 6'b001111);
      chk({8'h00, flagWord}, 16'h0083);
      cmd(CMD_FLAG_UPDATE, 3'h0, 16'h0000, 5'h00, 6'b110100);
      chk({8'h00, flagWord}, 16'h00C3);
      @(posedge clock) irqRequest <= 7'h04;
      quiet();
      cmd(CMD_MASK_ALL, 3'h0, 16'h0000, 5'h00, 6'h00);
      chk({8'h00, flagWord}, 16'h0043);
      wr(3'h3, 16'h0000);
      quiet();
      for (int s = 0; s < 7; s++) begin
         cmd(CMD_MASK_ALL, 3'h0, 16'h0000, 5'h00, 6'h00);
         @(posedge clock) irqRequest <= 7'h7F << s;
         cmd(CMD_UNMASK_ALL, 3'h0, 16'h0000, 5'h00, 6'h00);
         chk({8'h00, flagWord}, 16'h00C3);
         for (int i = 0; i < 20 && irqAck !== 1'b1; i++) begin
            @(posedge clock);
            #1;
         end
         chk({11'h000, irqAck, irqAckSource, flagWord[7]}, {11'h000, 1'b1, 3'(s), 1'b0});
         idle();
         chk(fetchPointer, vec(16'h0006 + 16'(2 * s)));
         chk(stackPointer, 16'hFEFB);
         @(posedge clock) irqRequest <= 7'h00;
         cmd(CMD_INT_RETURN, 3'h0, 16'h0000, 5'h00, 6'h00);
         @(posedge clock);
         #1;
         chk({flagWord, stackPointer[7:0]}, 16'hC3FE);
         chk(fetchPointer, fe);
      end
      // Push from the bottom of the range wraps into the register area
      wr(3'h2, 16'h0000);
      cmd(CMD_PUSH_FLAGS, 3'h0, 16'h0000, 5'h00, 6'h00);
      chk({14'h0000, memRegion}, {14'h0000, REGION_SFR});
      chk(stackPointer, 16'hFFFF);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
